// file: shared/ess_pkg.sv
package ess_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] ADDR_FIFO_CTL  = 8'h3a;
  localparam logic [7:0] ADDR_TIMING    = 8'h3d;
  localparam logic [7:0] ADDR_POWER     = 8'h3f;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h42;

  // Field positions and reset values.
  localparam int unsigned TIM_SYNC_BIT  = 0;
  localparam int unsigned TIM_CLK_BIT   = 1;
  localparam int unsigned TIM_ODR_LSB   = 5;
  localparam int unsigned TIM_ODR_MSB   = 7;
  localparam logic [7:0]  TIMING_RESET  = 8'h00;
  localparam logic [1:0]  MODE_RESET    = 2'h0;
  localparam logic [1:0]  FIFO_RESET    = 2'h0;

  // Operating modes.
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKEUP  = 2'h1;
  localparam logic [1:0] MODE_INSTANT = 2'h2;
  localparam logic [1:0] MODE_MEASURE = 2'h3;

  // FIFO modes; bypass starts no new set and empties the FIFO.
  localparam logic [1:0] FIFO_BYPASS = 2'h0;

  // Timing constants.
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned ODR_SLOW_HZ  = 320;
  localparam int unsigned ODR_BASE_CYC = CLK_HZ / ODR_SLOW_HZ;
  localparam int unsigned EXT_BASE_DIV = 16;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_AX0, SEQ_AX1, SEQ_AX2} ess_seq_e;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } ess_axes_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ess_reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ess_reg_rsp_s;

endpackage : ess_pkg

// file: src/ess_sync_ctrl.sv
`timescale 1ns/1ps
module ess_sync_ctrl #(
  parameter int unsigned DEPTH       = 64,
  parameter int unsigned ODR_BASE    = ess_pkg::ODR_BASE_CYC,
  parameter int unsigned EXT_DIV     = ess_pkg::EXT_BASE_DIV,
  parameter logic [1:0]  AXIS_ROTATE = 2'h0
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Register port
  input  wire ess_pkg::ess_reg_req_s reg_req,
  output      ess_pkg::ess_reg_rsp_s reg_rsp,
  // Interrupt pins
  input  wire logic                 first_interrupt_pin_in,
  output      logic                 first_interrupt_pin_out,
  output      logic                 first_interrupt_pin_oe,
  input  wire logic                 second_interrupt_pin_in,
  // Converter
  input  wire ess_pkg::ess_axes_s   accel,
  output      logic                 conv_active
);
  import ess_pkg::*;

  localparam int unsigned AW       = $clog2(DEPTH);
  localparam logic [AW:0] SET_ROOM = (AW+1)'(DEPTH - 3);

  typedef struct packed {
    logic [7:0]    timing;
    logic [1:0]    mode;
    logic [1:0]    fifo_mode;
    logic [2:0]    i1s;
    logic [2:0]    i2s;
    logic [31:0]   div;
    ess_seq_e      seq;
    ess_axes_s     smp;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          phase;
    logic [7:0]    lsb;
    logic          pend;
    logic          pend_pop;
    logic [7:0]    pend_data;
    ess_reg_rsp_s  rsp;
    logic          i1o;
    logic          i1oe;
    logic          conv;
  } ess_state_s;

  ess_state_s st;
  ess_state_s next_st;
  logic [15:0] mem_q;
  logic [15:0] push_word;
  logic        push;
  logic        external_clock_select;
  logic        sync_sel;
  logic        meas;
  logic        i1_edge;
  logic        i2_edge;
  logic        rate_tick;
  logic        start;
  logic [31:0] limit;

  function automatic logic [31:0] odr_div(input logic [31:0] base, input logic [2:0] code);
    logic [31:0] d;
    d = base >> code;
    return (d == 32'h0) ? 32'h1 : d;
  endfunction : odr_div

  function automatic logic [15:0] axis_word(input ess_axes_s a, input logic [1:0] slot);
    logic [2:0] k;
    k = {1'b0, slot} + {1'b0, AXIS_ROTATE};
    if (k >= 3'h3) begin
      k = k - 3'h3;
    end
    if (k == 3'h0) begin
      return a.x;
    end else if (k == 3'h1) begin
      return a.y;
    end else begin
      return a.z;
    end
  endfunction : axis_word

  ess_word_mem #(.WIDTH(16), .DEPTH(DEPTH)) u_mem (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (st.wp),
    .wr_data (push_word),
    .rd_addr (st.rp),
    .rd_data (mem_q)
  );

  assign external_clock_select  = st.timing[TIM_CLK_BIT];
  assign sync_sel = st.timing[TIM_SYNC_BIT];
  assign meas     = (st.mode == MODE_MEASURE);
  assign i1_edge  = st.i1s[1] & ~st.i1s[2];
  assign i2_edge  = st.i2s[1] & ~st.i2s[2];
  assign limit    = odr_div(external_clock_select ? 32'(EXT_DIV) : 32'(ODR_BASE), st.timing[TIM_ODR_MSB:TIM_ODR_LSB]);
  assign push     = (st.seq != SEQ_IDLE);
  assign push_word = axis_word(st.smp, 2'(st.seq) - 2'h1);

  always_comb begin
    next_st = st;
    rate_tick = 1'b0;
    next_st.rsp.valid = 1'b0;
    next_st.pend = 1'b0;
    next_st.pend_pop = 1'b0;
    // The first flop of each chain feeds only the second.
    next_st.i1s = {st.i1s[1:0], first_interrupt_pin_in};
    next_st.i2s = {st.i2s[1:0], second_interrupt_pin_in};

    // Only measurement mode starts a sample; a set already started still finishes storing in the other modes.
    if (!meas) begin
      next_st.div = 32'h0;
    end else if (external_clock_select ? i1_edge : 1'b1) begin
      if (st.div >= limit - 32'h1) begin
        next_st.div = 32'h0;
        rate_tick = 1'b1;
      end else begin
        next_st.div = st.div + 32'h1;
      end
    end

    start = meas && (sync_sel ? i2_edge : rate_tick);

    case (st.seq)
      SEQ_IDLE: begin
        if (start && st.fifo_mode != FIFO_BYPASS && st.cnt <= SET_ROOM) begin
          next_st.smp = accel;
          next_st.seq = SEQ_AX0;
        end
      end
      SEQ_AX0: next_st.seq = SEQ_AX1;
      SEQ_AX1: next_st.seq = SEQ_AX2;
      default: next_st.seq = SEQ_IDLE;
    endcase

    if (push) begin
      next_st.wp = st.wp + 1'b1;
      next_st.cnt = next_st.cnt + 1'b1;
    end

    if (reg_req.rd) begin
      next_st.pend = 1'b1;
      next_st.pend_data = 8'h00;
      if (reg_req.addr == ADDR_FIFO_DATA) begin
        next_st.phase = ~st.phase;
        if (st.phase) begin
          next_st.pend_data = st.lsb;
        end else if (st.cnt != '0) begin
          next_st.pend_pop = 1'b1;
          next_st.rp = st.rp + 1'b1;
          next_st.cnt = next_st.cnt - 1'b1;
        end
      end else if (reg_req.addr == ADDR_TIMING) begin
        next_st.pend_data = st.timing;
      end else if (reg_req.addr == ADDR_POWER) begin
        next_st.pend_data = {6'h00, st.mode};
      end else if (reg_req.addr == ADDR_FIFO_CTL) begin
        next_st.pend_data = {6'h00, st.fifo_mode};
      end
    end

    if (st.pend) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = st.pend_pop ? mem_q[15:8] : st.pend_data;
      if (st.pend_pop) begin
        next_st.lsb = mem_q[7:0];
      end else if (st.pend_data == 8'h00 && st.phase) begin
        next_st.lsb = 8'h00;
      end
    end

    if (reg_req.wr) begin
      if (reg_req.addr == ADDR_TIMING) begin
        next_st.timing = reg_req.wdata;
      end else if (reg_req.addr == ADDR_POWER) begin
        next_st.mode = reg_req.wdata[1:0];
      end else if (reg_req.addr == ADDR_FIFO_CTL) begin
        next_st.fifo_mode = reg_req.wdata[1:0];
        // Bypass empties the FIFO, beating any push in the same cycle.
        if (reg_req.wdata[1:0] == FIFO_BYPASS) begin
          next_st.cnt = '0;
          next_st.rp = next_st.wp;
          next_st.phase = 1'b0;
        end
      end
    end

    next_st.i1o = (next_st.cnt > SET_ROOM);
    // The pin is only driven while it is not the clock input.
    next_st.i1oe = ~next_st.timing[TIM_CLK_BIT];
    next_st.conv = (next_st.mode == MODE_MEASURE) &&
                   (!next_st.timing[TIM_SYNC_BIT] || next_st.seq != SEQ_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{timing: TIMING_RESET, mode: MODE_RESET, fifo_mode: FIFO_RESET, seq: SEQ_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rsp                 = st.rsp;
  assign first_interrupt_pin_out = st.i1o;
  assign first_interrupt_pin_oe  = st.i1oe;
  assign conv_active             = st.conv;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ext_clock_tick_a: assert property (meas && external_clock_select && !i1_edge |=> st.div == $past(st.div))
    else $error("divider moved without an external clock edge");
  sync_start_a: assert property (meas && sync_sel && i2_edge && st.seq == SEQ_IDLE && st.cnt <= SET_ROOM
    && st.fifo_mode != FIFO_BYPASS |=> st.seq == SEQ_AX0 && st.smp == $past(accel))
    else $error("trigger did not start a sample");
  axis_order_a: assert property (st.seq == SEQ_AX0 |=> st.seq == SEQ_AX1 ##1 st.seq == SEQ_AX2
    ##1 st.seq == SEQ_IDLE)
    else $error("axis words out of sequence");
  first_word_a: assert property (st.seq == SEQ_AX0 |-> push && push_word == ((AXIS_ROTATE == 2'h0) ? st.smp.x
    : (AXIS_ROTATE == 2'h1) ? st.smp.y : st.smp.z))
    else $error("first stored word is not the set's leading axis");
  conv_idle_a: assert property (sync_sel && !i2_edge && st.seq == SEQ_IDLE |=> st.seq == SEQ_IDLE
    && st.wp == $past(st.wp))
    else $error("sample stored without a trigger");
  bypass_clear_a: assert property (reg_req.wr && reg_req.addr == ADDR_FIFO_CTL && reg_req.wdata[1:0] == FIFO_BYPASS
    |=> st.cnt == '0 ##1 st.cnt == '0)
    else $error("bypass did not empty the FIFO");
  mode_idle_a: assert property (!meas |=> st.div == 32'h0 && (st.seq == SEQ_IDLE || $past(st.seq) != SEQ_IDLE))
    else $error("sampling started outside measurement mode");
  pop_once_a: assert property (reg_req.rd && reg_req.addr == ADDR_FIFO_DATA && !st.phase && st.cnt != '0
    && !(reg_req.wr && reg_req.addr == ADDR_FIFO_CTL) |=> st.rp == $past(st.rp) + 1'b1 ##1 reg_rsp.valid)
    else $error("FIFO data read did not pop one word");
  lsb_hold_a: assert property (reg_req.rd && reg_req.addr == ADDR_FIFO_DATA && st.phase
    |=> st.rp == $past(st.rp) || $past(reg_req.wr))
    else $error("second byte read popped the FIFO");
  read_lat_a: assert property (reg_req.rd |-> ##2 reg_rsp.valid)
    else $error("read answer not two cycles after request");

  sync_sample_c: cover property (sync_sel && i2_edge && meas ##1 st.seq == SEQ_AX0);
  ext_clock_c:   cover property (external_clock_select && rate_tick);
  fifo_full_c:   cover property ($rose(first_interrupt_pin_out));
  pop_c:         cover property (reg_req.rd && reg_req.addr == ADDR_FIFO_DATA && st.cnt != '0);

endmodule : ess_sync_ctrl

// file: src/ess_word_mem.sv
`timescale 1ns/1ps
module ess_word_mem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic             clk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output      logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Read before write: a word written at an edge is seen one edge later.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : ess_word_mem

// file: testbench/ess_host_pins.sv
`timescale 1ns/1ps
module ess_host_pins (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Commands from the bench
  input  wire logic clk_run,
  input  wire logic trig,
  // Device pins
  input  wire logic pin1_out,
  input  wire logic pin1_oe,
  output      logic pin1_in,
  output      logic pin2_in
);
  logic       external_clock_select = 1'b0;
  logic [2:0] hold;
  // The host clock is unrelated in phase and stands still outside bursts.
  always #100 external_clock_select = clk_run ? ~external_clock_select : 1'b0;
  assign pin1_in = pin1_oe ? pin1_out : external_clock_select;
  // The trigger stays low unless commanded, which keeps the converter off while sync mode is selected.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold <= 3'h0;
    end else if (trig) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign pin2_in = (hold != 3'h0);
endmodule : ess_host_pins

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import ess_pkg::*;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  ess_reg_req_s rq = '0;
  ess_reg_rsp_s rs;
  ess_axes_s    accel = '0;
  logic         p1_in, p1_out, p1_oe, p2_in, conv;
  logic         run = 1'b0;
  logic         trig = 1'b0;
  logic [15:0]  mq[$];
  logic [15:0]  lf = 16'h0018;
  logic [7:0]   rd_val;
  int           miscompares = 0;
  int           num_checks = 0;
  int           cyc = 0;

  ess_sync_ctrl #(.DEPTH(8), .ODR_BASE(40), .EXT_DIV(2), .AXIS_ROTATE(2'h0)) u_ess_sync_ctrl (
    .clk(clk), .rstn(rstn), .reg_req(rq), .reg_rsp(rs), .first_interrupt_pin_in(p1_in),
    .first_interrupt_pin_out(p1_out), .first_interrupt_pin_oe(p1_oe),
    .second_interrupt_pin_in(p2_in), .accel(accel), .conv_active(conv));
  ess_host_pins u_ess_host_pins (.clk(clk), .rstn(rstn), .clk_run(run), .trig(trig),
    .pin1_out(p1_out), .pin1_oe(p1_oe), .pin1_in(p1_in), .pin2_in(p2_in));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    rq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    rq.rd <= 1'b0;
    rd_val = 8'hxx;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (rs.valid === 1'b1) begin
        rd_val = rs.data;
        break;
      end
      @(posedge clk);
    end
  endtask : reg_rd

  // Pops n words; an empty model queue means the device must return zeros.
  task automatic drain(input int n);
    logic [15:0] w;
    for (int i = 0; i < n; i++) begin
      w = (mq.size() > 0) ? mq.pop_front() : 16'h0000;
      reg_rd(ADDR_FIFO_DATA);
      check("fifo msb", {8'h00, rd_val}, {8'h00, w[15:8]});
      reg_rd(ADDR_FIFO_DATA);
      check("fifo lsb", {8'h00, rd_val}, {8'h00, w[7:0]});
    end
  endtask : drain

  task automatic push_set();
    mq.push_back(accel.x);
    mq.push_back(accel.y);
    mq.push_back(accel.z);
  endtask : push_set

  task automatic fire(input logic counts);
    @(posedge clk);
    lf = lfsr(lf);
    accel.x <= lf;
    lf = lfsr(lf);
    accel.y <= lf;
    lf = lfsr(lf);
    accel.z <= lf;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (16) @(posedge clk);
    if (counts) begin
      push_set();
    end
  endtask : fire

  task automatic wait_full(input int lim);
    for (int i = 0; i < lim && p1_out !== 1'b1; i++) begin
      @(posedge clk);
    end
    #1;
  endtask : wait_full

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Ceiling is over 25 times the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check("oe after reset", {15'h0, p1_oe}, 16'h0001);
    reg_rd(ADDR_TIMING);
    check("timing reset", {8'h00, rd_val}, {8'h00, TIMING_RESET});
    reg_rd(8'h10);
    check("unmapped read", {8'h00, rd_val}, 16'h0000);
    $display("test reset done");
    reg_wr(ADDR_FIFO_CTL, 8'h01);
    reg_wr(ADDR_TIMING, 8'h01);
    reg_rd(ADDR_TIMING);
    check("timing readback", {8'h00, rd_val}, 16'h0001);
    for (int m = 0; m < 3; m++) begin
      reg_wr(ADDR_POWER, m[7:0]);
      fire(1'b0);
    end
    reg_wr(ADDR_POWER, {6'h00, MODE_MEASURE});
    repeat (200) @(posedge clk);
    #1;
    check("converter idle", {15'h0, conv}, 16'h0000);
    drain(1);
    $display("test init done");
    fire(1'b1);
    fire(1'b1);
    drain(7);
    $display("test triggers done");
    reg_wr(ADDR_TIMING, 8'h00);
    wait_full(400);
    check("full flag", {15'h0, p1_out}, 16'h0001);
    check("converter on", {15'h0, conv}, 16'h0001);
    reg_wr(ADDR_TIMING, 8'h01);
    push_set();
    push_set();
    drain(6);
    reg_wr(ADDR_FIFO_CTL, 8'h00);
    reg_wr(ADDR_FIFO_CTL, 8'h01);
    #1;
    check("full cleared", {15'h0, p1_out}, 16'h0000);
    $display("test main loop done");
    reg_wr(ADDR_TIMING, 8'h22);
    repeat (200) @(posedge clk);
    #1;
    check("oe released", {15'h0, p1_oe}, 16'h0000);
    check("no clock no data", {15'h0, p1_out}, 16'h0000);
    @(posedge clk);
    run <= 1'b1;
    wait_full(400);
    check("ext clock fill", {15'h0, p1_out}, 16'h0001);
    @(posedge clk);
    run <= 1'b0;
    reg_wr(ADDR_TIMING, 8'h01);
    push_set();
    push_set();
    drain(3);
    // Bypass with a set still stored must leave nothing behind to read.
    reg_wr(ADDR_FIFO_CTL, 8'h00);
    mq.delete();
    reg_wr(ADDR_FIFO_CTL, 8'h01);
    #1;
    check("bypass level", {15'h0, p1_out}, 16'h0000);
    drain(1);
    $display("test external clock done");
    complete_run();
  end
endmodule : tb
